//--- core/cbchg_bank.v
// Notes on behaviour
// RQ1 - trickle current from bits 15:14
// RQ2 - reverse-output start debounce chosen by bit 13
// RQ3 - two-level input limit enabled by bit 12
// RQ4 - switch gate turn-on debounce chosen by bit 11
// RQ5 - first insertion after reset always short delay; code uses the bit 11 delay if reverse mode has already dropped the gate
// RQ6 - input and discharge alerts debounced by 10:9
// RQ7 - low rail alert fixed short debounce
// RQ8 - alert held minimum time chosen by 8:6
// RQ9 - bit 5 keeps gate off in reverse mode
// RQ10 - comparator reference chosen by bit 4
// RQ11 - bit 3 disables comparator
// RQ12 - bit 2 inverts comparator output polarity
// RQ13 - bit 1 disables gross overcurrent protection
// RQ14 - bit 0 selects power monitor gain
// RQ15 - host writes voltage word at 0x49
// RQ16 - voltage field bits 12:7, 128mV weights
// RQ17 - voltage field clamped 100110 to 101010
// RQ18 - host writes current word at 0x4a
// RQ19 - current field bits 12:7, 128mA weights
// RQ20 - current field clamped at 100000
// RQ21 - enable input rise starts reverse debounce
// RQ22 - reset clears second control to zero
// RQ23 - unused bits ignore writes, read zero
`timescale 1ns/1ps
`include "cbchg_map.vh"

// one alert path: assertion debounce then minimum hold
module cbchg_alert
(
    input wire core_clk,
    input wire reset,
    input wire raw,
    input wire [16:0] db_limit,
    input wire [21:0] dur_limit,
    output reg alert_q
);
    reg [16:0] db_cnt_q; // cycles the raw condition has stood
    reg [21:0] hold_cnt_q; // cycles since assertion

    // debounce, assert, hold, release
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            alert_q <= 1'b0;
            db_cnt_q <= 17'h0_0000;
            hold_cnt_q <= 22'h00_0000;
        end
        else if (!alert_q)
        begin
            hold_cnt_q <= 22'h00_0000;
            if (!raw)
                db_cnt_q <= 17'h0_0000; // glitch restarts count
            else if (db_cnt_q == db_limit - 17'h0_0001)
            begin
                alert_q <= 1'b1; // RQ6
                db_cnt_q <= 17'h0_0000;
            end
            else
                db_cnt_q <= db_cnt_q + 17'h0_0001;
        end
        else if (hold_cnt_q < dur_limit)
            hold_cnt_q <= hold_cnt_q + 22'h00_0001; // RQ8
        else if (!raw)
            alert_q <= 1'b0; // RQ8
    end
endmodule // cbchg_alert

// second control, reverse-output limits and the logic they steer
module cbchg_bank
#(
    parameter [27:0] P_DB_LONG = `CBCHG_MS_CYC(`CBCHG_DB_LONG_MS),
    parameter [27:0] P_DB_SHORT = `CBCHG_MS_CYC(`CBCHG_DB_SHORT_MS),
    parameter [16:0] P_AL_100US = `CBCHG_US_CYC(`CBCHG_AL_100_US),
    parameter [16:0] P_AL_500US = `CBCHG_US_CYC(`CBCHG_AL_500_US),
    parameter [16:0] P_AL_1MS = `CBCHG_US_CYC(`CBCHG_AL_1000_US),
    parameter [21:0] P_DUR_20MS = `CBCHG_MS_CYC(`CBCHG_DUR_20_MS),
    parameter [21:0] P_DUR_15MS = `CBCHG_MS_CYC(`CBCHG_DUR_15_MS),
    parameter [21:0] P_DUR_10MS = `CBCHG_MS_CYC(`CBCHG_DUR_10_MS),
    parameter [21:0] P_DUR_5MS = `CBCHG_MS_CYC(`CBCHG_DUR_5_MS),
    parameter [21:0] P_DUR_1MS = `CBCHG_MS_CYC(`CBCHG_DUR_1_MS),
    parameter [21:0] P_DUR_500US = `CBCHG_US_CYC(`CBCHG_AL_500_US),
    parameter [21:0] P_DUR_100US = `CBCHG_US_CYC(`CBCHG_AL_100_US)
)
(
    input wire core_clk,
    input wire reset,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    output reg [15:0] rd_data_q,
    output reg rd_valid_q,
    input wire reverse_enable,
    input wire adapter_present,
    input wire input_current_over,
    input wire discharge_over,
    input wire low_rail_under,
    input wire comparator_input_above_ref,
    output reg [9:0] trickle_current_ma_q,
    output reg reverse_active_q,
    output reg two_level_limit_en_q,
    output reg adapter_switch_gate_q,
    output reg input_current_hot_alert_q,
    output reg discharge_hot_alert_q,
    output reg low_rail_hot_alert_q,
    output reg hot_alert_n_q,
    output reg comparator_ref_high_q,
    output reg comparator_output_q,
    output reg gross_overcurrent_protect_en_q,
    output reg platform_power_monitor_gain_low_q,
    output reg [5:0] reverse_voltage_field_q,
    output reg [5:0] reverse_current_field_q
);
    // fixed low rail debounce, under 4096 cycles
    localparam [16:0] AL_10US = `CBCHG_US_CYC(`CBCHG_AL_10_US);
    // one-hot states, shared by both debounce machines
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_ON = 3'h4;

    reg [15:0] ctrl2_q; // second_control word
    reg [5:0] rvolt_d; // clamped voltage field
    reg [5:0] rcurr_d; // clamped current field
    reg [2:0] otg_st_q; // reverse-output start machine
    reg [27:0] otg_cnt_q; // reverse start debounce counter
    reg en_prev_q; // enable level last cycle
    reg [2:0] asg_st_q; // adapter gate machine
    reg [27:0] asg_cnt_q; // gate debounce counter
    reg gate_seen_off_q; // gate dropped once since reset
    reg gate_d; // next gate level
    reg [27:0] otg_limit; // selected reverse start delay
    reg [27:0] asg_limit; // selected gate delay
    reg [16:0] al_db; // selected alert debounce
    reg [21:0] al_dur; // selected alert minimum hold
    wire ic_alert; // input current alert path
    wire dc_alert; // discharge alert path
    wire lr_alert; // low rail alert path
    wire [5:0] wfld; // value field of write word

    assign wfld = cmd_wdata[`CBCHG_FLD_HI:`CBCHG_FLD_LO];

    // clamp written fields; unused bits never stored
    always @*
    begin
        rvolt_d = wfld;
        if (wfld > `CBCHG_RVOLT_MAX)
            rvolt_d = `CBCHG_RVOLT_MAX; // RQ17
        else if (wfld < `CBCHG_RVOLT_MIN)
            rvolt_d = `CBCHG_RVOLT_MIN; // RQ17
        rcurr_d = wfld;
        if (wfld > `CBCHG_RCURR_MAX)
            rcurr_d = `CBCHG_RCURR_MAX; // RQ20
    end

    // register writes and reads
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl2_q <= `CBCHG_CTRL2_RST; // RQ22
            reverse_voltage_field_q <= `CBCHG_RVOLT_RST;
            reverse_current_field_q <= `CBCHG_RCURR_RST;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= cmd_valid & ~cmd_write;
            if (cmd_valid && cmd_write)
            begin
                case (cmd_code)
                    `CBCHG_ADDR_CTRL2: ctrl2_q <= cmd_wdata;
                    `CBCHG_ADDR_RVOLT: reverse_voltage_field_q <= rvolt_d; // RQ16
                    `CBCHG_ADDR_RCURR: reverse_current_field_q <= rcurr_d; // RQ19
                    default: ; // unmapped codes ignored
                endcase
            end
            if (cmd_valid && !cmd_write)
            begin
                case (cmd_code)
                    `CBCHG_ADDR_CTRL2: rd_data_q <= ctrl2_q;
                    `CBCHG_ADDR_RVOLT:
                        rd_data_q <= {3'h0, reverse_voltage_field_q, 7'h00}; // RQ23
                    `CBCHG_ADDR_RCURR:
                        rd_data_q <= {3'h0, reverse_current_field_q, 7'h00}; // RQ23
                    default: rd_data_q <= 16'h0000; // unmapped reads zero
                endcase
            end
        end
    end

    // delay selection from the control word
    always @*
    begin
        otg_limit = ctrl2_q[`CBCHG_OTG_DB_BIT] ? P_DB_SHORT : P_DB_LONG; // RQ2
        // short delay until the gate has dropped once
        if (!gate_seen_off_q)
            asg_limit = P_DB_SHORT; // RQ5
        else if (ctrl2_q[`CBCHG_ASG_DB_BIT])
            asg_limit = P_DB_SHORT; // RQ4
        else
            asg_limit = P_DB_LONG; // RQ4
        case (ctrl2_q[`CBCHG_ALDB_HI:`CBCHG_ALDB_LO])
            2'h0: al_db = AL_10US; // RQ6
            2'h1: al_db = P_AL_100US;
            2'h2: al_db = P_AL_500US;
            default: al_db = P_AL_1MS;
        endcase
        case (ctrl2_q[`CBCHG_ALDUR_HI:`CBCHG_ALDUR_LO])
            3'h0: al_dur = P_DUR_10MS; // RQ8
            3'h1: al_dur = P_DUR_20MS;
            3'h2: al_dur = P_DUR_15MS;
            3'h3: al_dur = P_DUR_5MS;
            3'h4: al_dur = P_DUR_1MS;
            3'h5: al_dur = P_DUR_500US;
            3'h6: al_dur = P_DUR_100US;
            default: al_dur = 22'h00_0000; // zero hold
        endcase
    end

    // reverse-output start debounce machine
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            otg_st_q <= ST_IDLE;
            otg_cnt_q <= 28'h000_0000;
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= reverse_enable;
            case (otg_st_q)
                ST_IDLE:
                begin
                    otg_cnt_q <= 28'h000_0000;
                    if (reverse_enable && !en_prev_q)
                        otg_st_q <= ST_WAIT; // RQ21
                end
                ST_WAIT:
                begin
                    if (!reverse_enable)
                        otg_st_q <= ST_IDLE; // command withdrawn
                    else if (otg_cnt_q >= otg_limit - 28'h000_0001)
                        otg_st_q <= ST_ON; // RQ2
                    else
                        otg_cnt_q <= otg_cnt_q + 28'h000_0001;
                end
                ST_ON:
                    if (!reverse_enable)
                        otg_st_q <= ST_IDLE; // RQ21
                default: otg_st_q <= ST_IDLE;
            endcase
        end
    end

    // adapter switch gate debounce machine
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            asg_st_q <= ST_IDLE;
            asg_cnt_q <= 28'h000_0000;
        end
        else
        begin
            case (asg_st_q)
                ST_IDLE:
                begin
                    asg_cnt_q <= 28'h000_0000;
                    if (adapter_present)
                        asg_st_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (!adapter_present)
                        asg_st_q <= ST_IDLE; // removed during debounce
                    else if (asg_cnt_q >= asg_limit - 28'h000_0001)
                        asg_st_q <= ST_ON; // RQ4
                    else
                        asg_cnt_q <= asg_cnt_q + 28'h000_0001;
                end
                ST_ON:
                    if (!adapter_present)
                        asg_st_q <= ST_IDLE;
                default: asg_st_q <= ST_IDLE;
            endcase
        end
    end

    // gate level: reverse mode overrides the adapter path
    always @*
    begin
        if (otg_st_q == ST_ON)
            gate_d = ~ctrl2_q[`CBCHG_ASG_OTG_BIT]; // RQ9
        else
            gate_d = (asg_st_q == ST_ON);
    end

    // alert paths; low rail uses the fixed debounce
    cbchg_alert u_ic_alert
    (
        .core_clk(core_clk),
        .reset(reset),
        .raw(input_current_over),
        .db_limit(al_db),
        .dur_limit(al_dur),
        .alert_q(ic_alert)
    );
    cbchg_alert u_dc_alert
    (
        .core_clk(core_clk),
        .reset(reset),
        .raw(discharge_over),
        .db_limit(al_db),
        .dur_limit(al_dur),
        .alert_q(dc_alert)
    );
    cbchg_alert u_lr_alert
    (
        .core_clk(core_clk),
        .reset(reset),
        .raw(low_rail_under),
        .db_limit(AL_10US), // RQ7
        .dur_limit(al_dur),
        .alert_q(lr_alert)
    );

    // registered outputs
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            trickle_current_ma_q <= `CBCHG_TRKL_MA_00;
            reverse_active_q <= 1'b0;
            two_level_limit_en_q <= 1'b0;
            adapter_switch_gate_q <= 1'b0;
            gate_seen_off_q <= 1'b0; // RQ5
            input_current_hot_alert_q <= 1'b0;
            discharge_hot_alert_q <= 1'b0;
            low_rail_hot_alert_q <= 1'b0;
            hot_alert_n_q <= 1'b1;
            comparator_ref_high_q <= 1'b0;
            comparator_output_q <= 1'b0;
            gross_overcurrent_protect_en_q <= 1'b1;
            platform_power_monitor_gain_low_q <= 1'b0;
        end
        else
        begin
            case (ctrl2_q[`CBCHG_TRKL_HI:`CBCHG_TRKL_LO])
                2'h0: trickle_current_ma_q <= `CBCHG_TRKL_MA_00; // RQ1
                2'h1: trickle_current_ma_q <= `CBCHG_TRKL_MA_01; // RQ1
                2'h2: trickle_current_ma_q <= `CBCHG_TRKL_MA_10; // RQ1
                default: trickle_current_ma_q <= `CBCHG_TRKL_MA_11; // RQ1
            endcase
            reverse_active_q <= (otg_st_q == ST_ON); // RQ2
            two_level_limit_en_q <= ctrl2_q[`CBCHG_TWO_LVL_BIT]; // RQ3
            adapter_switch_gate_q <= gate_d;
            if (adapter_switch_gate_q && !gate_d)
                gate_seen_off_q <= 1'b1; // RQ5
            input_current_hot_alert_q <= ic_alert;
            discharge_hot_alert_q <= dc_alert;
            low_rail_hot_alert_q <= lr_alert;
            hot_alert_n_q <= ~(ic_alert | dc_alert | lr_alert);
            comparator_ref_high_q <= ctrl2_q[`CBCHG_CMP_REF_BIT]; // RQ10
            // disabled comparator rests at its inactive level
            if (ctrl2_q[`CBCHG_CMP_DIS_BIT])
                comparator_output_q <= ctrl2_q[`CBCHG_CMP_POL_BIT]; // RQ11
            else
                comparator_output_q <= comparator_input_above_ref
                    ^ ctrl2_q[`CBCHG_CMP_POL_BIT]; // RQ12
            gross_overcurrent_protect_en_q <=
                ~ctrl2_q[`CBCHG_WOC_DIS_BIT]; // RQ13
            platform_power_monitor_gain_low_q <=
                ctrl2_q[`CBCHG_PMON_GAIN_BIT]; // RQ14
        end
    end
endmodule // cbchg_bank

//--- core/cbchg_map.vh
`ifndef CBCHG_MAP_VH
`define CBCHG_MAP_VH
// command codes of the three word registers
`define CBCHG_ADDR_CTRL2 8'h3d
`define CBCHG_ADDR_RVOLT 8'h49
`define CBCHG_ADDR_RCURR 8'h4a
// second_control field positions
`define CBCHG_TRKL_HI 15
`define CBCHG_TRKL_LO 14
`define CBCHG_OTG_DB_BIT 13
`define CBCHG_TWO_LVL_BIT 12
`define CBCHG_ASG_DB_BIT 11
`define CBCHG_ALDB_HI 10
`define CBCHG_ALDB_LO 9
`define CBCHG_ALDUR_HI 8
`define CBCHG_ALDUR_LO 6
`define CBCHG_ASG_OTG_BIT 5
`define CBCHG_CMP_REF_BIT 4
`define CBCHG_CMP_DIS_BIT 3
`define CBCHG_CMP_POL_BIT 2
`define CBCHG_WOC_DIS_BIT 1
`define CBCHG_PMON_GAIN_BIT 0
// reset values
`define CBCHG_CTRL2_RST 16'h0000
`define CBCHG_RVOLT_RST 6'h26
`define CBCHG_RCURR_RST 6'h00
// value field of both reverse-output registers
`define CBCHG_FLD_HI 12
`define CBCHG_FLD_LO 7
`define CBCHG_RVOLT_MIN 6'h26
`define CBCHG_RVOLT_MAX 6'h2a
`define CBCHG_RCURR_MAX 6'h20
// trickle current in mA
`define CBCHG_TRKL_MA_00 10'h100
`define CBCHG_TRKL_MA_01 10'h080
`define CBCHG_TRKL_MA_10 10'h040
`define CBCHG_TRKL_MA_11 10'h200
// clock and times
`define CBCHG_CLK_NS 8
`define CBCHG_DB_LONG_MS 1300
`define CBCHG_DB_SHORT_MS 150
`define CBCHG_AL_10_US 10
`define CBCHG_AL_100_US 100
`define CBCHG_AL_500_US 500
`define CBCHG_AL_1000_US 1000
`define CBCHG_DUR_20_MS 20
`define CBCHG_DUR_15_MS 15
`define CBCHG_DUR_10_MS 10
`define CBCHG_DUR_5_MS 5
`define CBCHG_DUR_1_MS 1
`define CBCHG_MS_CYC(t) ((t) * 1000000 / `CBCHG_CLK_NS)
`define CBCHG_US_CYC(t) ((t) * 1000 / `CBCHG_CLK_NS)
`endif

//--- sim/cbchg_bank_props.sv
`timescale 1ns/1ps
// port-level checks of the control bank
module cbchg_bank_props
#(
    parameter [27:0] P_DB_LONG = 28'h00c8,
    parameter [27:0] P_DB_SHORT = 28'h0028
)
(
    input wire core_clk,
    input wire reset,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire reverse_enable,
    input wire low_rail_under,
    input wire comparator_input_above_ref,
    input wire [9:0] trickle_current_ma_q,
    input wire reverse_active_q,
    input wire two_level_limit_en_q,
    input wire adapter_switch_gate_q,
    input wire discharge_hot_alert_q,
    input wire low_rail_hot_alert_q,
    input wire comparator_ref_high_q,
    input wire comparator_output_q,
    input wire gross_overcurrent_protect_en_q,
    input wire platform_power_monitor_gain_low_q,
    input wire [5:0] reverse_voltage_field_q,
    input wire [5:0] reverse_current_field_q
);
    reg [15:0] c2_q; // mirror of second control
    reg [8:0] en_cnt_q; // cycles enable has stayed high
    wire [27:0] lim = c2_q[13] ? P_DB_SHORT : P_DB_LONG; // start wait
    wire [5:0] wf = cmd_wdata[12:7]; // written value field
    wire wr_c2 = cmd_valid && cmd_write && cmd_code == 8'h3d;
    wire wr_v = cmd_valid && cmd_write && cmd_code == 8'h49;
    wire wr_i = cmd_valid && cmd_write && cmd_code == 8'h4a;
    // track control writes and enable time
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            c2_q <= 16'h0000;
            en_cnt_q <= 9'h000;
        end
        else
        begin
            if (wr_c2)
                c2_q <= cmd_wdata;
            if (!reverse_enable)
                en_cnt_q <= 9'h000;
            else if (en_cnt_q != 9'h1ff)
                en_cnt_q <= en_cnt_q + 9'h001;
        end
    end
    // trickle current in mA per code
    function [9:0] trk(input [1:0] c);
        trk = c[1] ? (c[0] ? 10'h200 : 10'h040) : (c[0] ? 10'h080 : 10'h100);
    endfunction
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);
    a_trickle_code: assert property (
        wr_c2 |-> ##2 trickle_current_ma_q == trk($past(cmd_wdata[15:14], 2)))
        else $error("trickle current wrong");
    a_limit_ref: assert property (
        wr_c2 |-> ##2 {two_level_limit_en_q, comparator_ref_high_q} ==
        {$past(cmd_wdata[12], 2), $past(cmd_wdata[4], 2)})
        else $error("limit or reference wrong");
    a_protect_gain: assert property (
        wr_c2 |-> ##2 {gross_overcurrent_protect_en_q,
        platform_power_monitor_gain_low_q} ==
        {!$past(cmd_wdata[1], 2), $past(cmd_wdata[0], 2)})
        else $error("protect or gain wrong");
    a_cmp_out: assert property (
        (!$past(reset) && $stable(c2_q) &&
        $stable(comparator_input_above_ref))[*3] |->
        comparator_output_q == (c2_q[3] ? c2_q[2] :
        comparator_input_above_ref ^ c2_q[2]))
        else $error("comparator output wrong");
    a_gate_reverse: assert property (
        (reverse_active_q && $stable(c2_q))[*3] |->
        adapter_switch_gate_q == !c2_q[5])
        else $error("gate wrong in reverse mode");
    a_volt_clamp: assert property (
        wr_v |=> reverse_voltage_field_q == ($past(wf) < 6'h26 ? 6'h26 :
        $past(wf) > 6'h2a ? 6'h2a : $past(wf)))
        else $error("voltage field wrong");
    a_curr_clamp: assert property (
        wr_i |=> reverse_current_field_q ==
        ($past(wf) > 6'h20 ? 6'h20 : $past(wf)))
        else $error("current field wrong");
    a_low_rail_db: assert property (
        $rose(low_rail_hot_alert_q) |-> $past(low_rail_under, 1000))
        else $error("low rail alert too early");
    a_alert_hold: assert property (
        $rose(discharge_hot_alert_q) && c2_q[8:6] != 3'h7 |=>
        discharge_hot_alert_q[*8])
        else $error("alert released too soon");
    a_rev_late: assert property (
        en_cnt_q == lim + 8 |-> reverse_active_q)
        else $error("reverse output late");
    a_rev_early: assert property (
        en_cnt_q > 2 && en_cnt_q < lim - 2 |-> !reverse_active_q)
        else $error("reverse output early");
    c_rev: cover property ($rose(reverse_active_q));
    c_gate: cover property ($rose(adapter_switch_gate_q));
    c_low: cover property ($rose(low_rail_hot_alert_q));
endmodule // cbchg_bank_props

//--- sim/cbchg_host.sv
`timescale 1ns/1ps
// word-access host on the decoded register port
module cbchg_host
(
    input wire core_clk,
    output reg cmd_valid,
    output reg cmd_write,
    output reg [7:0] cmd_code,
    output reg [15:0] cmd_wdata,
    input wire [15:0] rd_data_q,
    input wire rd_valid_q
);
    // idle port at start
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // whole 16-bit word write, code picks the register
    task wr(input [7:0] code, input [15:0] data);
    begin
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~data; // data stale once released
    end
    endtask
    // word read, answer taken on its pulse edge
    task rd(input [7:0] code, output [15:0] data, output ok);
    begin
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b0;
        cmd_code <= code;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        @(posedge core_clk);
        data = rd_data_q;
        ok = rd_valid_q;
    end
    endtask
endmodule // cbchg_host

//--- sim/cbchg_bank_bench.sv
`timescale 1ns/1ps
// drives the bank through the host model
module cbchg_bank_bench;
    reg core_clk = 1'b0; // 125 MHz
    reg reset = 1'b1; // power-on reset
    reg reverse_enable = 1'b0;
    reg adapter_present = 1'b0;
    reg input_current_over = 1'b0;
    reg discharge_over = 1'b0;
    reg low_rail_under = 1'b0;
    reg comparator_input_above_ref = 1'b0;
    wire cmd_valid, cmd_write, rd_valid_q;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, rd_data_q;
    wire [9:0] trickle_current_ma_q;
    wire [5:0] reverse_voltage_field_q, reverse_current_field_q;
    wire reverse_active_q, two_level_limit_en_q, adapter_switch_gate_q;
    wire input_current_hot_alert_q, discharge_hot_alert_q;
    wire low_rail_hot_alert_q, hot_alert_n_q, comparator_ref_high_q;
    wire comparator_output_q, gross_overcurrent_protect_en_q;
    wire platform_power_monitor_gain_low_q;
    wire [4:0] mon = {low_rail_hot_alert_q, discharge_hot_alert_q,
        input_current_hot_alert_q, reverse_active_q, adapter_switch_gate_q};
    integer num_errors = 0;
    integer n_tests = 0;
    integer n, i;
    reg [15:0] rv; // read-back word
    reg ok; // read answer seen
    reg [39:0] e; // code, write word, expected read
    reg [63:0] tk = 64'h0100_0080_0040_0200; // trickle mA per code
    reg [279:0] vt = {40'h49_ffff_1500, 40'h49_0000_1300,
        40'h49_f47f_1400, 40'h4a_ffff_1000, 40'h4a_0f80_0f80,
        40'h4a_e07f_0000, 40'h3c_1234_0000};
    cbchg_bank #(.P_DB_LONG(200), .P_DB_SHORT(40), .P_AL_100US(20),
        .P_AL_500US(40), .P_AL_1MS(60), .P_DUR_10MS(30),
        .P_DUR_20MS(50)) dut (.*);
    cbchg_host host (.*);
    always #4 core_clk = ~core_clk;
    // compare and count
    task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("ERROR %0s exp %h seen %h", name, exp, seen);
        end
    end
    endtask
    // read one register and compare
    task rdc(input [7:0] c, input [15:0] x);
    begin
        host.rd(c, rv, ok);
        check("valid", ok, 16'h0001);
        check("rdata", rv, x);
    end
    endtask
    // count edges until a monitored output reaches a level
    task wait_lv(input integer sel, input lv);
    begin
        n = 0;
        while (mon[sel] !== lv && n < 3000)
        begin
            @(posedge core_clk);
            n = n + 1;
        end
    end
    endtask
    // check the waited count lies near the expected count
    task rng(input integer lo);
        check("cycles", (n >= lo - 2 && n <= lo + 6), 16'h0001);
    endtask
    // unplug, plug and time the gate
    task plug(input integer lo);
    begin
        @(posedge core_clk);
        adapter_present <= 1'b0;
        wait_lv(0, 1'b0);
        @(posedge core_clk); // one drive per edge on the pin
        adapter_present <= 1'b1;
        wait_lv(0, 1'b1);
        rng(lo);
    end
    endtask
    // one input current alert: debounce, then minimum hold
    task alert_run(input [15:0] w, input integer db, input integer dur);
    begin
        host.wr(8'h3d, w);
        input_current_over <= 1'b1;
        wait_lv(2, 1'b1);
        rng(db);
        input_current_over <= 1'b0;
        @(posedge core_clk);
        check("alertn", hot_alert_n_q, 16'h0000);
        wait_lv(2, 1'b0);
        rng(dur);
    end
    endtask
    // print counts and verdict
    task conclude;
    begin
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors = num_errors + 1;
        conclude;
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rdc(8'h3d, 16'h0000);
        rdc(8'h49, 16'h1300);
        check("prot", gross_overcurrent_protect_en_q, 16'h0001);
        plug(40);
        plug(200);
        host.wr(8'h3d, 16'h0800);
        plug(40);
        for (i = 0; i < 4; i = i + 1)
        begin
            host.wr(8'h3d, {i[1:0], 14'h0000});
            repeat (2) @(posedge core_clk);
            check("trickle", trickle_current_ma_q, tk[63-16*i -: 16]);
        end
        comparator_input_above_ref <= 1'b1;
        host.wr(8'h3d, 16'h101f);
        repeat (3) @(posedge core_clk);
        check("twolvl", two_level_limit_en_q, 16'h0001);
        check("ref", comparator_ref_high_q, 16'h0001);
        check("prot", gross_overcurrent_protect_en_q, 16'h0000);
        check("gain", platform_power_monitor_gain_low_q, 16'h0001);
        check("cmpdis", comparator_output_q, 16'h0001);
        rdc(8'h3d, 16'h101f);
        host.wr(8'h3d, 16'h0004);
        repeat (3) @(posedge core_clk);
        check("cmpout", comparator_output_q, 16'h0000);
        host.wr(8'h3d, 16'h0000);
        repeat (3) @(posedge core_clk);
        check("cmpout", comparator_output_q, 16'h0001);
        for (i = 0; i < 7; i = i + 1)
        begin
            e = vt[279-40*i -: 40];
            host.wr(e[39:32], e[31:16]);
            rdc(e[39:32], e[15:0]);
        end
        rdc(8'h49, 16'h1400);
        adapter_present <= 1'b0;
        host.wr(8'h3d, 16'h2000);
        reverse_enable <= 1'b1;
        wait_lv(1, 1'b1);
        rng(40);
        repeat (3) @(posedge core_clk);
        check("gate", adapter_switch_gate_q, 16'h0001);
        host.wr(8'h3d, 16'h2020);
        repeat (3) @(posedge core_clk);
        check("gate", adapter_switch_gate_q, 16'h0000);
        reverse_enable <= 1'b0;
        wait_lv(1, 1'b0);
        host.wr(8'h3d, 16'h0000);
        reverse_enable <= 1'b1;
        wait_lv(1, 1'b1);
        rng(200);
        reverse_enable <= 1'b0;
        alert_run(16'h0200, 20, 30);
        alert_run(16'h0440, 40, 50);
        alert_run(16'h03c0, 20, 0);
        host.wr(8'h3d, 16'h0600);
        discharge_over <= 1'b1;
        wait_lv(3, 1'b1);
        rng(60);
        discharge_over <= 1'b0;
        low_rail_under <= 1'b1;
        wait_lv(4, 1'b1);
        rng(1250);
        low_rail_under <= 1'b0;
        conclude;
    end
endmodule // cbchg_bank_bench
bind cbchg_bank cbchg_bank_props #(.P_DB_LONG(P_DB_LONG),
    .P_DB_SHORT(P_DB_SHORT)) u_props (.*);
